// ### sid_pkg.sv
// shared constants, types and state codes for the safety input diagnosis block
package sid_pkg;

  // ----------------------------------------------------------------
  // sizes and function codes
  // ----------------------------------------------------------------
  localparam int         NUM_IN    = 6;      // duplicated inputs
  localparam int         NUM_FUNC  = 8;      // function code space
  localparam logic [3:0] FUNC_NONE = 4'h0;   // no function assigned
  localparam logic [2:0] IDX_END   = 3'h6;   // scan index past last input

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS        = 100;   // 10 MHz system clock
  localparam int POWER_ON_DIAG_NS     = 1000;  // internal power-on check
  localparam int POWER_ON_DIAG_CYCLES =
    (POWER_ON_DIAG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TP_PERIOD_US         = 1000;  // test pulse repeat time
  localparam int TP_PERIOD_CYCLES     = TP_PERIOD_US * 1000 / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0][3:0]  input_function_select; // function per input
    logic [5:0][15:0] mismatch_time;         // cycles, 0 = no check
    logic [5:0][15:0] filter_time;           // cycles of stability
    logic [5:0]       test_pulse_select_1;   // diag channel a wires
    logic [5:0]       test_pulse_select_2;   // diag channel b wires
    logic [15:0]      test_pulse_off_time;   // off-pulse width, cycles
    logic [5:0]       startup_diag_select_1; // start-up target set 1
    logic [5:0]       startup_diag_select_2; // start-up target set 2
  } cfg_t;

  typedef struct packed {
    logic mismatch_alarm;      // sticky
    logic safe_stop_1;         // sticky
    logic input_device_alarm;  // sticky
    logic startup_warning;     // high until start-up check ends
    logic safe_torque_off;     // high until start-up check ends
  } status_t;

  localparam status_t STATUS_RESET = 5'h03;  // warning and stop held

  typedef enum logic [5:0] {
    ST_POWER_ON    = 6'h01,
    ST_SCAN        = 6'h02,
    ST_WAIT_OFF    = 6'h04,
    ST_WAIT_ON     = 6'h08,
    ST_WAIT_ALL_ON = 6'h10,
    ST_DONE        = 6'h20
  } startup_state_t;

endpackage

// ### sid_filter.sv
// noise rejection filter for one input wire
`timescale 1ns/1ps
module sid_filter (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_raw,    // unfiltered wire level
  input  wire logic [15:0] i_time,   // stable cycles required
  output logic             o_level   // filtered level
);

  logic [15:0] cnt_reg;  // cycles the raw level has differed

  // ----------------------------------------------------------------
  // stability counter, level follows only after a full stable run
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_reg <= 16'h0000;
      o_level <= 1'b0;
    end else if (i_raw == o_level) begin  // any bounce restarts the run
      cnt_reg <= 16'h0000;
    end else if (cnt_reg >= i_time) begin  // [RL21] [RL20] [RL17]
      o_level <= i_raw;
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_filter_stable;
    @(posedge i_clk) disable iff (!i_reset_n)
      (o_level != $past(o_level)) |-> ($past(cnt_reg) >= $past(i_time));
  endproperty
  a_filter_stable: assert property (p_filter_stable) // [RL21]
    else $error("filter level changed before stable time");

endmodule // sid_filter

// ### sid_input_diag.sv
// duplicated safety input checking, start-up check, test pulses, filtering
//
// Behaviour
// [RL1] - wires disagree means logical command off
// [RL2] - command on only when both wires on
// [RL3] - long disagreement raises alarm and safe stop
// [RL4] - zero mismatch time disables that check
// [RL5] - far party switches both wires promptly
// [RL6] - start-up toggles each target input singly
// [RL7] - far party holds other inputs on
// [RL8] - all targets passed clears warning and stop
// [RL9] - targets need function and start-up selection
// [RL10] - no targets: internal check, wait all on
// [RL11] - periodic off-pulses on both test outputs
// [RL12] - test outputs never off together
// [RL13] - off-pulse width follows one setting
// [RL14] - test pulse wiring fault raises device alarm
// [RL15] - per-wire test selection, zero means none
// [RL16] - shared pulse shorts stay undetected
// [RL17] - separate filter time per input
// [RL18] - filter time should exceed pulse off time
// [RL19] - input drives its assigned function command
// [RL20] - filter delays effect by filter time
// [RL21] - level passes after full stable time
// [RL22] - input must read off during own pulse
`timescale 1ns/1ps
module sid_input_diag #(
  parameter int P_TP_PERIOD_CYCLES = sid_pkg::TP_PERIOD_CYCLES  // >= 4
) (
  input  wire logic              I_CLK_SYS,
  input  wire logic              I_RESET_N,
  input  wire logic [5:0]        I_INPUT_CHANNEL_A,  // a wires, 1 = on
  input  wire logic [5:0]        I_INPUT_CHANNEL_B,  // b wires, 1 = on
  input  wire sid_pkg::cfg_t     I_CFG,              // static settings
  output logic [5:0]             O_INPUT_COMMAND,    // logical commands
  output logic [7:0]             O_FUNCTION_COMMAND, // per function code
  output logic                   O_TEST_PULSE_OUT_A,
  output logic                   O_TEST_PULSE_OUT_B,
  output sid_pkg::status_t       O_STATUS
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [5:0]        filt_a;         // filtered a wires
  logic [5:0]        filt_b;         // filtered b wires
  logic [5:0]        over;           // mismatch time exceeded
  logic [5:0]        assigned;       // input has a function
  logic [5:0]        target;         // start-up check targets
  logic [7:0]        func_next;      // function command next value
  logic [15:0]       period;         // test pulse period, cycles
  logic [15:0]       half;           // offset of the b pulse
  logic [15:0]       off_eff;        // clamped off-pulse width
  logic [15:0]       tp_cnt_reg;     // test pulse phase
  logic              fail_a;         // a wire on during own pulse
  logic              fail_b;         // b wire on during own pulse
  logic              mm_alarm_reg;   // mismatch alarm
  logic              stop1_reg;      // safe stop 1 request
  logic              dev_alarm_reg;  // input device alarm
  logic              warn_reg;       // start-up warning
  logic              sto_reg;        // safe torque off held
  logic [2:0]        idx_reg;        // input under start-up check
  logic [15:0]       pon_cnt_reg;    // power-on check timer
  sid_pkg::startup_state_t state_reg;
  sid_pkg::startup_state_t state_next;

  assign period = P_TP_PERIOD_CYCLES[15:0];
  assign half   = {1'b0, period[15:1]};

  // ----------------------------------------------------------------
  // per input filters and mismatch timers
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < sid_pkg::NUM_IN; gi++) begin : g_in
      logic [15:0] mm_cnt_reg;  // cycles of disagreement, saturating
      sid_filter u_filt_a (
        .i_clk     (I_CLK_SYS),
        .i_reset_n (I_RESET_N),
        .i_raw     (I_INPUT_CHANNEL_A[gi]),
        .i_time    (I_CFG.filter_time[gi]),  // [RL17]
        .o_level   (filt_a[gi])
      );
      sid_filter u_filt_b (
        .i_clk     (I_CLK_SYS),
        .i_reset_n (I_RESET_N),
        .i_raw     (I_INPUT_CHANNEL_B[gi]),
        .i_time    (I_CFG.filter_time[gi]),
        .o_level   (filt_b[gi])
      );
      // timer runs only while the filtered wires disagree
      always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
          mm_cnt_reg <= 16'h0000;
        end else if (filt_a[gi] == filt_b[gi]) begin
          mm_cnt_reg <= 16'h0000;
        end else if (mm_cnt_reg != 16'hffff) begin
          mm_cnt_reg <= mm_cnt_reg + 16'h0001;
        end
      end
      // zero setting never trips [RL4]
      assign over[gi] = (filt_a[gi] != filt_b[gi]) &&
                        (I_CFG.mismatch_time[gi] != 16'h0000) &&
                        (mm_cnt_reg >= I_CFG.mismatch_time[gi]);  // [RL3]
      assign assigned[gi] = I_CFG.input_function_select[gi] != sid_pkg::FUNC_NONE;
    end
  endgenerate

  // start-up targets: assigned and selected in either set [RL9]
  assign target = assigned & (I_CFG.startup_diag_select_1 | I_CFG.startup_diag_select_2);

  // ----------------------------------------------------------------
  // logical commands
  // ----------------------------------------------------------------
  // both wires on gives on, any disagreement gives off
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_INPUT_COMMAND <= 6'h00;
    end else begin
      O_INPUT_COMMAND <= filt_a & filt_b;  // [RL1] [RL2]
    end
  end

  // route each command to the function it is assigned to
  always_comb begin
    func_next = 8'h00;
    for (int i = 0; i < sid_pkg::NUM_IN; i++) begin
      if (assigned[i] && O_INPUT_COMMAND[i]) begin
        func_next[I_CFG.input_function_select[i][2:0]] = 1'b1;  // [RL19]
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_FUNCTION_COMMAND <= 8'h00;
    end else begin
      O_FUNCTION_COMMAND <= func_next;
    end
  end

  // ----------------------------------------------------------------
  // mismatch alarm, sticky until reset
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      mm_alarm_reg <= 1'b0;
      stop1_reg    <= 1'b0;
    end else if (|over) begin  // alarm and stop start together [RL3]
      mm_alarm_reg <= 1'b1;
      stop1_reg    <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // test pulse generator
  // ----------------------------------------------------------------
  // width clamped below half a period so the pulses cannot overlap
  always_comb begin
    if (I_CFG.test_pulse_off_time == 16'h0000) begin
      off_eff = 16'h0001;
    end else if (I_CFG.test_pulse_off_time >= half) begin
      off_eff = half - 16'h0001;  // [RL12]
    end else begin
      off_eff = I_CFG.test_pulse_off_time;  // [RL13]
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      tp_cnt_reg <= 16'h0000;
    end else if (tp_cnt_reg >= period - 16'h0001) begin
      tp_cnt_reg <= 16'h0000;
    end else begin
      tp_cnt_reg <= tp_cnt_reg + 16'h0001;  // [RL11]
    end
  end

  // a pulses at phase 0, b at half period
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_TEST_PULSE_OUT_A <= 1'b1;
      O_TEST_PULSE_OUT_B <= 1'b1;
    end else begin
      O_TEST_PULSE_OUT_A <= !(tp_cnt_reg < off_eff);  // [RL11] [RL13]
      O_TEST_PULSE_OUT_B <= !((tp_cnt_reg >= half) &&
                              (tp_cnt_reg < half + off_eff));  // [RL12]
    end
  end

  // ----------------------------------------------------------------
  // test pulse check on the last cycle of each off-pulse
  // ----------------------------------------------------------------
  // raw wires are read so the filter cannot hide the pulse; a short
  // between wires on the same pulse output still passes [RL16]
  assign fail_a = (tp_cnt_reg == off_eff) &&
                  |(I_CFG.test_pulse_select_1 & I_INPUT_CHANNEL_A);  // [RL22] [RL15]
  assign fail_b = (tp_cnt_reg == half + off_eff) &&
                  |(I_CFG.test_pulse_select_2 & I_INPUT_CHANNEL_B);  // [RL22] [RL15]

  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      dev_alarm_reg <= 1'b0;
    end else if (fail_a || fail_b) begin
      dev_alarm_reg <= 1'b1;  // [RL14]
    end
  end

  // ----------------------------------------------------------------
  // start-up check sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      sid_pkg::ST_POWER_ON: begin  // internal check first [RL10]
        if (pon_cnt_reg >= 16'(sid_pkg::POWER_ON_DIAG_CYCLES - 1)) begin
          state_next = (target == 6'h00) ? sid_pkg::ST_WAIT_ALL_ON : sid_pkg::ST_SCAN;
        end
      end
      sid_pkg::ST_SCAN: begin  // untargeted inputs are skipped [RL9]
        if (idx_reg >= sid_pkg::IDX_END) begin
          state_next = sid_pkg::ST_DONE;  // [RL8]
        end else if (target[idx_reg]) begin
          state_next = sid_pkg::ST_WAIT_OFF;
        end
      end
      sid_pkg::ST_WAIT_OFF: begin  // see the input go off [RL6]
        if (!O_INPUT_COMMAND[idx_reg]) begin
          state_next = sid_pkg::ST_WAIT_ON;
        end
      end
      sid_pkg::ST_WAIT_ON: begin  // and back on [RL6]
        if (O_INPUT_COMMAND[idx_reg]) begin
          state_next = sid_pkg::ST_SCAN;
        end
      end
      sid_pkg::ST_WAIT_ALL_ON: begin  // every assigned input on [RL10]
        if ((O_INPUT_COMMAND | ~assigned) == 6'h3f) begin
          state_next = sid_pkg::ST_DONE;
        end
      end
      sid_pkg::ST_DONE: begin
        state_next = sid_pkg::ST_DONE;
      end
      default: begin
        state_next = sid_pkg::ST_POWER_ON;
      end
    endcase
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state_reg   <= sid_pkg::ST_POWER_ON;
      idx_reg     <= 3'h0;
      pon_cnt_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      if (state_reg == sid_pkg::ST_POWER_ON) begin
        pon_cnt_reg <= pon_cnt_reg + 16'h0001;
      end
      // next index after a pass or a skip
      if ((state_reg == sid_pkg::ST_SCAN && state_next == sid_pkg::ST_SCAN) ||
          (state_reg == sid_pkg::ST_WAIT_ON && state_next == sid_pkg::ST_SCAN)) begin
        idx_reg <= idx_reg + 3'h1;
      end
    end
  end

  // warning and stop held until the sequencer is done
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      warn_reg <= 1'b1;
      sto_reg  <= 1'b1;
    end else begin
      warn_reg <= (state_next != sid_pkg::ST_DONE);  // [RL8] [RL10]
      sto_reg  <= (state_next != sid_pkg::ST_DONE);  // [RL8] [RL10]
    end
  end

  assign O_STATUS = {mm_alarm_reg, stop1_reg, dev_alarm_reg, warn_reg, sto_reg};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [15:0] off_run_a;  // length of the current a off-pulse
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      off_run_a <= 16'h0000;
    end else begin
      off_run_a <= O_TEST_PULSE_OUT_A ? 16'h0000 : off_run_a + 16'h0001;
    end
  end

  property p_cmd_off_mismatch;
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
      ((filt_a ^ filt_b) != 6'h00) |=> ((O_INPUT_COMMAND & $past(filt_a ^ filt_b)) == 6'h00);
  endproperty
  a_cmd_off_mismatch: assert property (p_cmd_off_mismatch) // [RL1]
    else $error("command on while wires disagree");

  property p_cmd_needs_both;
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
      $rose(O_INPUT_COMMAND[0]) |-> $past(filt_a[0] && filt_b[0]);
  endproperty
  a_cmd_needs_both: assert property (p_cmd_needs_both) // [RL2]
    else $error("command rose without both wires on");

  property p_alarm_with_stop;
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
      $rose(mm_alarm_reg) |-> stop1_reg && $past(|over);
  endproperty
  a_alarm_with_stop: assert property (p_alarm_with_stop) // [RL3]
    else $error("mismatch alarm without cause or stop");

  property p_zero_time_silent;
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
      (I_CFG.mismatch_time[0] == 16'h0000) |-> !over[0];
  endproperty
  a_zero_time_silent: assert property (p_zero_time_silent) // [RL4]
    else $error("mismatch check active with zero time");

  property p_no_overlap;
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
      O_TEST_PULSE_OUT_A || O_TEST_PULSE_OUT_B;
  endproperty
  a_no_overlap: assert property (p_no_overlap) // [RL12]
    else $error("both test outputs off together");

  property p_pulse_width;
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
      $rose(O_TEST_PULSE_OUT_A) |-> (off_run_a == $past(off_eff));
  endproperty
  a_pulse_width: assert property (p_pulse_width) // [RL13]
    else $error("test pulse width differs from setting");

  property p_dev_alarm_cause;
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
      $rose(dev_alarm_reg) |-> $past(fail_a || fail_b);
  endproperty
  a_dev_alarm_cause: assert property (p_dev_alarm_cause) // [RL14]
    else $error("device alarm without pulse failure");

  property p_release_together;
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
      $fell(warn_reg) |-> $fell(sto_reg) && state_reg == sid_pkg::ST_DONE;
  endproperty
  a_release_together: assert property (p_release_together) // [RL8]
    else $error("warning and stop not released together");

  c_mismatch_alarm: cover property (@(posedge I_CLK_SYS) $rose(mm_alarm_reg));
  c_startup_done: cover property (@(posedge I_CLK_SYS) $fell(warn_reg));
  c_device_alarm: cover property (@(posedge I_CLK_SYS) $rose(dev_alarm_reg));

endmodule // sid_input_diag

// ### sid_switch_model.sv
// far side model: duplicated switches fed by the two test pulse outputs
`timescale 1ns/1ps
module sid_switch_model #(
  parameter logic [5:0] P_FEED = 6'h13  // inputs whose switches hang on the pulse outputs
) (
  input  wire logic       i_test_pulse_out_a,  // feeds every fed a switch
  input  wire logic       i_test_pulse_out_b,  // feeds every fed b switch
  input  wire logic [5:0] i_switch_a,          // a contact closed
  input  wire logic [5:0] i_switch_b,          // b contact closed
  input  wire logic [5:0] i_short_a,           // a wire shorted to supply
  input  wire logic [5:0] i_short_b,           // b wire shorted to supply
  output logic      [5:0] o_channel_a,         // a wires into the block
  output logic      [5:0] o_channel_b          // b wires into the block
);
  // ----------------------------------------------------------------
  // contact network
  // ----------------------------------------------------------------
  // one pulse output is shared by all fed inputs, so a short between
  // two fed wires of the same channel looks healthy from here
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      o_channel_a[i] = i_short_a[i] |
                       (i_switch_a[i] & (P_FEED[i] ? i_test_pulse_out_a : 1'b1));
      o_channel_b[i] = i_short_b[i] |
                       (i_switch_b[i] & (P_FEED[i] ? i_test_pulse_out_b : 1'b1));
    end
  end
endmodule // sid_switch_model

// ### tb_sid_input_diag.sv
// self-checking bench for the duplicated safety input block
`timescale 1ns/1ps
module tb_sid_input_diag;
  localparam int P = 40;             // short pulse period keeps the run brief
  logic            clk, rst_n;       // clock and active-low reset
  logic [5:0]      sw_a, sw_b, sh_a, sh_b; // switch contacts and wiring faults
  logic [5:0]      ch_a, ch_b;       // wires into the block
  sid_pkg::cfg_t   cfg;              // static settings
  logic [5:0]      cmd;              // logical commands
  logic [7:0]      func;             // function commands
  logic            tpa, tpb;         // test pulse outputs
  sid_pkg::status_t st;              // alarms and start-up flags
  int              num_errors, checks, n;

  sid_input_diag #(.P_TP_PERIOD_CYCLES(P)) dut_u (
    .I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_INPUT_CHANNEL_A(ch_a),
    .I_INPUT_CHANNEL_B(ch_b), .I_CFG(cfg), .O_INPUT_COMMAND(cmd),
    .O_FUNCTION_COMMAND(func), .O_TEST_PULSE_OUT_A(tpa),
    .O_TEST_PULSE_OUT_B(tpb), .O_STATUS(st));
  sid_switch_model sw_u (.i_test_pulse_out_a(tpa), .i_test_pulse_out_b(tpb),
    .i_switch_a(sw_a), .i_switch_b(sw_b), .i_short_a(sh_a), .i_short_b(sh_b),
    .o_channel_a(ch_a), .o_channel_b(ch_b));

  always #50 clk = ~clk;  // 10 MHz

  // ----------------------------------------------------------------
  // reporting and compare helpers
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %b", $time, what, got);
    end
  endtask
  task automatic chk_vec(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h", $time, what, got);
    end
  endtask
  task automatic chk_int(input int got, input int lo, input int hi, input string what);
    checks++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("mismatch at %0t: %s got %0d", $time, what, got);
    end
  endtask
  // watched signal: 0..5 command bit, 6 warning, 7 mismatch alarm, 8 device alarm
  function automatic logic sig(input int s);
    if (s < 6) return cmd[s];
    if (s == 6) return st.startup_warning;
    if (s == 7) return st.mismatch_alarm;
    return st.input_device_alarm;
  endfunction
  // counts edges until the signal shows the level; a spent bound ends the run
  task automatic wait_for(input int s, input logic v, input int bound, output int k);
    k = 0;
    while (sig(s) !== v && k < bound) begin
      @(negedge clk);
      k++;
    end
    if (sig(s) !== v) begin
      num_errors++;
      $display("mismatch at %0t: wait on signal %0d timed out", $time, s);
      print_verdict();
    end
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // two targets toggled singly; input 4 has no function so it is skipped
  task automatic startup_targets();
    do_reset();
    repeat (40) @(negedge clk);
    chk_bit(st.safe_torque_off, 1'b1, "stop held");
    for (int t = 0; t < 2; t++) begin
      sw_a[t] = 1'b0;
      sw_b[t] = 1'b0;
      wait_for(t, 1'b0, 60, n);
      sw_a[t] = 1'b1;
      sw_b[t] = 1'b1;
      wait_for(t, 1'b1, 60, n);
      if (t == 0) chk_bit(st.startup_warning, 1'b1, "warning early");
    end
    wait_for(6, 1'b0, 20, n);
    @(negedge clk);
    chk_bit(st.safe_torque_off, 1'b0, "stop released");
    chk_vec(func, 8'h1e, "functions");
  endtask
  // exact response to a drop, bounce rejection, one-wire disagreement
  task automatic filter_timing();
    int ft[2] = '{3, 7};
    bit ok;
    for (int i = 2; i < 4; i++) begin
      sw_a[i] = 1'b0;
      sw_b[i] = 1'b0;
      wait_for(i, 1'b0, 30, n);
      chk_int(n, ft[i-2] + 2, ft[i-2] + 2, "filter delay");
      @(negedge clk);
      chk_bit(func[i+1], 1'b0, "function follows");
      sw_a[i] = 1'b1;
      sw_b[i] = 1'b1;
      wait_for(i, 1'b1, 30, n);
    end
    sw_a[2] = 1'b0;
    repeat (3) @(negedge clk);
    sw_a[2] = 1'b1;
    ok = 1'b1;
    repeat (12) begin
      @(negedge clk);
      if (cmd[2] !== 1'b1) ok = 1'b0;
    end
    chk_bit(ok, 1'b1, "bounce passed");
    sw_a[2] = 1'b0;
    repeat (20) @(negedge clk);
    chk_bit(cmd[2], 1'b0, "a off b on");
    sw_a[2] = 1'b1;
    sw_b[2] = 1'b0;
    repeat (20) @(negedge clk);
    chk_bit(cmd[2], 1'b0, "a on b off");
    sw_b[2] = 1'b1;
    wait_for(2, 1'b1, 10, n);
    chk_bit(st.mismatch_alarm, 1'b0, "zero time trips");
  endtask
  // input 3: filter 7, mismatch time 20
  task automatic mismatch_alarm();
    sw_b[3] = 1'b0;
    wait_for(7, 1'b1, 60, n);
    chk_int(n, 27, 33, "alarm moment");
    chk_bit(st.safe_stop_1, 1'b1, "safe stop");
    sw_b[3] = 1'b1;
  endtask
  // off-pulse width, period and separation of the two outputs
  task automatic test_pulses(input int off);
    int arun, brun, last, both;
    logic pa, pb;
    cfg.test_pulse_off_time = 16'(off);
    repeat (P) @(negedge clk);
    arun = 0; brun = 0; last = -1; both = 0; pa = tpa; pb = tpb;
    for (int c = 0; c < 2 * P + 2; c++) begin
      @(negedge clk);
      if (tpa === 1'b0 && tpb === 1'b0) both++;
      if (tpa === 1'b0) arun++;
      if (tpb === 1'b0) brun++;
      if (pa === 1'b1 && tpa === 1'b0) begin
        if (last >= 0) chk_int(c - last, P, P, "pulse period");
        last = c;
      end
      if (c >= off && pa === 1'b0 && tpa === 1'b1) chk_int(arun, off, off, "a width");
      if (c >= off && pb === 1'b0 && tpb === 1'b1) chk_int(brun, off, off, "b width");
      if (tpa === 1'b1) arun = 0;
      if (tpb === 1'b1) brun = 0;
      pa = tpa;
      pb = tpb;
    end
    chk_int(both, 0, 0, "both low");
    chk_int(last, 0, 2 * P, "pulses seen");
  endtask
  // stuck a wire on an unselected then a selected input
  task automatic pulse_fault();
    sh_a[4] = 1'b1;
    repeat (2 * P) @(negedge clk);
    chk_bit(st.input_device_alarm, 1'b0, "unselected fault");
    sh_a[0] = 1'b1;
    wait_for(8, 1'b1, P + 10, n);
    sh_a = 6'h00;
  endtask
  // no targets: release only once every assigned input is on; then a stuck b wire
  task automatic no_targets();
    cfg.startup_diag_select_1 = 6'h00;
    cfg.startup_diag_select_2 = 6'h00;
    sw_b[1] = 1'b0;
    do_reset();
    repeat (60) @(negedge clk);
    chk_bit(st.startup_warning, 1'b1, "warning with input off");
    sw_b[1] = 1'b1;
    wait_for(6, 1'b0, 40, n);
    @(negedge clk);
    chk_bit(st.safe_torque_off, 1'b0, "stop released");
    sh_b[1] = 1'b1;
    wait_for(8, 1'b1, P + 10, n);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0; rst_n = 1'b0; num_errors = 0; checks = 0;
    sw_a = 6'h3f; sw_b = 6'h3f; sh_a = 6'h00; sh_b = 6'h00;
    cfg = '0;
    cfg.input_function_select[0] = 4'h1;
    cfg.input_function_select[1] = 4'h2;
    cfg.input_function_select[2] = 4'h3;
    cfg.input_function_select[3] = 4'h4;
    cfg.filter_time = {16'h0004, 16'h0004, 16'h0007, 16'h0003, 16'h0004, 16'h0004};
    cfg.mismatch_time[3] = 16'h0014;
    cfg.test_pulse_select_1 = 6'h03;
    cfg.test_pulse_select_2 = 6'h03;
    cfg.test_pulse_off_time = 16'h0002;
    cfg.startup_diag_select_1 = 6'h11;
    cfg.startup_diag_select_2 = 6'h02;
    startup_targets();
    filter_timing();
    mismatch_alarm();
    test_pulses(2);
    test_pulses(3);
    pulse_fault();
    no_targets();
    print_verdict();
  end
endmodule // tb_sid_input_diag
